// ===== src/cic_ahb_front.sv
// AHB-Lite address phase capture for the imaging control bank
`timescale 1ns/1ps
`default_nettype none
module cic_ahb_front
  import cic_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] haddr,
  input  wire logic        hready,
  output logic             rdTake,
  output logic             rdHit,
  output cic_idx_t         rdIdx,
  output logic             wrPend_q,
  output logic             wrHit_q,
  output logic             wrRestart_q,
  output cic_idx_t         wrIdx_q
);
  logic        take;
  logic [IW:0] dec;

  // Sub-word accesses are not decoded: they complete OKAY with no effect
  assign take   = hsel && hready && htrans == HTRANS_NONSEQ
                  && hsize == HSIZE_WORD;
  assign dec    = cic_decode(haddr);
  assign rdTake = take && !hwrite;
  assign rdHit  = dec[IW];
  assign rdIdx  = dec[IW-1:0];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wrPend_q    <= 1'b0;
      wrHit_q     <= 1'b0;
      wrRestart_q <= 1'b0;
      wrIdx_q     <= '0;
    end else if (hready) begin
      wrPend_q    <= take && hwrite;
      wrHit_q     <= dec[IW];
      wrRestart_q <= haddr == {{(32-AW){1'b0}}, OFS_RESTART};
      wrIdx_q     <= dec[IW-1:0];
    end
  end
endmodule : cic_ahb_front
`default_nettype wire

// ===== src/cic_boot_loader.sv
// Walks the chosen configuration space into the working registers
`timescale 1ns/1ps
`default_nettype none
module cic_boot_loader
  import cic_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic [2:0]  bootSet,
  input  wire logic        cfgRdValid,
  input  wire logic [31:0] cfgRdData,
  output logic             busy,
  output logic             cfgRdReq_q,
  output logic [2:0]       cfgRdSet_q,
  output cic_idx_t         cfgRdIndex_q,
  output logic             ldWr_q,
  output cic_idx_t         ldIdx_q,
  output logic [31:0]      ldData_q
);
  cic_ld_state_t state_q;

  assign busy = state_q != LD_IDLE;

  // Reset state is LD_REQ so every power-up reloads the factory space, as reset clears the selector
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q      <= LD_REQ;
      cfgRdReq_q   <= 1'b0;
      cfgRdSet_q   <= '0;
      cfgRdIndex_q <= '0;
      ldWr_q       <= 1'b0;
      ldIdx_q      <= '0;
      ldData_q     <= '0;
    end else begin
      ldWr_q     <= 1'b0;
      cfgRdReq_q <= 1'b0;
      case (state_q)
        LD_IDLE: begin
          if (start) begin
            cfgRdIndex_q <= '0;
            state_q      <= LD_REQ;
          end
        end
        LD_REQ: begin
          cfgRdReq_q <= 1'b1;
          cfgRdSet_q <= bootSet;
          state_q    <= LD_WAIT;
        end
        LD_WAIT: begin
          if (cfgRdValid) begin
            ldWr_q   <= 1'b1;
            ldIdx_q  <= cfgRdIndex_q;
            ldData_q <= cfgRdData;
            if (cfgRdIndex_q == IX_LASTCFG) begin
              state_q <= LD_IDLE;
            end else begin
              cfgRdIndex_q <= cfgRdIndex_q + 5'h01;
              state_q      <= LD_REQ;
            end
          end
        end
        default: state_q <= LD_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence reqIssued;
    state_q == LD_REQ ##1 cfgRdReq_q && state_q == LD_WAIT;
  endsequence
  sequence wordStored;
    cfgRdValid && state_q == LD_WAIT ##1 ldWr_q && ldIdx_q == $past(cfgRdIndex_q);
  endsequence

  load_request_a: assert property (state_q == LD_REQ |-> reqIssued)
    else $error("load request not issued");
  load_store_a: assert property (
    cfgRdValid && state_q == LD_WAIT |-> wordStored)
    else $error("loaded word not stored");
endmodule : cic_boot_loader
`default_nettype wire

// ===== src/cic_camera_imaging_control_regs.sv
// Imaging control register bank on AHB-Lite with boot-time reload
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Boot selector: factory, four user sets, reserved
// - Reload factory set after reset, chosen set after restart
// - Nine-bit analog gain, 0.1 dB steps
// - Twelve-bit digital gain, 0.001x per step
// - Eleven-bit digital offset added to pixels
// - Region mode: off, faster rate, constant rate
// - Four thirteen-bit region window values
// - Separate horizontal and vertical 2:1 subsample enables
// - Vertical binning enable: none or 2x
// - Upside-down and mirror flip enables
// - Black level mode: user or automatic
// - Eight-bit user black level value
// - Exposure mode: off, pulse width, internal
// - Twenty-four-bit exposure time in microseconds
// - Frame time used only when long integration on
module cic_camera_imaging_control_regs
  import cic_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        cfgRdValid,
  input  wire logic [31:0] cfgRdData,
  output logic             cfgRdReq,
  output logic [2:0]       cfgRdSet,
  output logic [4:0]       cfgRdIndex,
  output logic             loadBusy,
  output logic [2:0]       bootSet,
  output logic [8:0]       analogGain,
  output logic [11:0]      pixelGain,
  output logic [10:0]      pixelOffset,
  output logic [1:0]       converterResolution,
  output logic [1:0]       masterRegionMode,
  output logic [12:0]      masterRegionHOffset,
  output logic [12:0]      masterRegionHWidth,
  output logic [12:0]      masterRegionVOffset,
  output logic [12:0]      masterRegionVHeight,
  output logic             hSubsampleEn,
  output logic             vSubsampleEn,
  output logic             vBinningEn,
  output logic             mirrorEn,
  output logic             upsideDownEn,
  output logic             blackLevelAuto,
  output logic [7:0]       blackLevelValue,
  output logic [1:0]       exposureMode,
  output logic [23:0]      exposureTimeUs,
  output logic             longIntegrationEn,
  output logic [23:0]      frameTimeUs,
  output logic [23:0]      autoExposureLowerUs,
  output logic [23:0]      autoExposureUpperUs
);
  logic [31:0] regQ [NUM_REG];
  logic        rdTake;
  logic        rdHit;
  cic_idx_t    rdIdx;
  logic        wrPend;
  logic        wrHit;
  logic        wrRestart;
  cic_idx_t    wrIdx;
  logic        busWr;
  logic        restartReq;
  logic        ldBusy;
  logic        ldWr;
  cic_idx_t    ldIdx;
  logic [31:0] ldData;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic        hresp_q;
  logic        loadBusy_q;
  logic        restart_q;
  logic [2:0]  bootSet_q;
  logic [1:0]  convRes_q;
  logic [1:0]  regionMode_q;
  logic [1:0]  expoMode_q;
  logic [23:0] frameTime_q;

  cic_ahb_front u_front (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .hsel        (hsel),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (hsize),
    .haddr       (haddr),
    .hready      (hready),
    .rdTake      (rdTake),
    .rdHit       (rdHit),
    .rdIdx       (rdIdx),
    .wrPend_q    (wrPend),
    .wrHit_q     (wrHit),
    .wrRestart_q (wrRestart),
    .wrIdx_q     (wrIdx)
  );

  cic_boot_loader u_loader (
    .clk_sys      (clk_sys),
    .nrst         (nrst),
    .start        (restart_q),
    .bootSet      (bootSet_q),
    .cfgRdValid   (cfgRdValid),
    .cfgRdData    (cfgRdData),
    .busy         (ldBusy),
    .cfgRdReq_q   (cfgRdReq),
    .cfgRdSet_q   (cfgRdSet),
    .cfgRdIndex_q (cfgRdIndex),
    .ldWr_q       (ldWr),
    .ldIdx_q      (ldIdx),
    .ldData_q     (ldData)
  );

  // Data phase completes only while this slave is ready
  assign busWr      = wrPend && hreadyout_q;
  assign restartReq = busWr && wrRestart && hwdata == RESTART_KEY;

  // Register storage; the loader and the bus never write in the same cycle
  // because the bus is stalled for the whole reload
  for (genvar gi = 0; gi < NUM_REG; gi++) begin : g_reg
    localparam logic [31:0] MASK = cic_mask(REG_BITS[gi]);
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        regQ[gi] <= '0;
      end else if (busWr && wrHit && wrIdx == IW'(gi)) begin
        regQ[gi] <= hwdata & MASK;
      end else if (ldWr && ldIdx == IW'(gi)) begin
        regQ[gi] <= ldData & MASK;
      end
    end
    reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (regQ[gi] & ~MASK) == '0)
      else $error("reserved register bits set");
  end

  // Bus answer: zero wait states outside a reload, unmapped reads return zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hrdata_q <= '0;
    end else if (rdTake) begin
      hrdata_q <= rdHit ? regQ[rdIdx] : '0;
    end
  end

  // Stall starts the cycle after the restart data phase so no write races the reload
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hreadyout_q <= 1'b0;
      loadBusy_q  <= 1'b1;
    end else begin
      hreadyout_q <= !(ldBusy || restartReq || restart_q);
      loadBusy_q  <= ldBusy || restartReq || restart_q;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hresp_q <= HRESP_OKAY;
    end else begin
      hresp_q <= HRESP_OKAY;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= restartReq;
    end
  end

  // Boot selector: values above the last user set fall back to factory
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bootSet_q <= BOOT_FACTORY;
    end else if (regQ[IX_BOOT][2:0] > BOOT_USER4) begin
      bootSet_q <= BOOT_FACTORY;
    end else begin
      bootSet_q <= regQ[IX_BOOT][2:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      convRes_q <= ADC_8;
    end else if (regQ[IX_ADCRES][1:0] > ADC_12) begin
      convRes_q <= ADC_8;
    end else begin
      convRes_q <= regQ[IX_ADCRES][1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      regionMode_q <= REGION_OFF;
    end else if (regQ[IX_RMODE][1:0] > REGION_CONST) begin
      regionMode_q <= REGION_OFF;
    end else begin
      regionMode_q <= regQ[IX_RMODE][1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      expoMode_q <= EXPO_OFF;
    end else if (regQ[IX_EMODE][1:0] > EXPO_TIMED) begin
      expoMode_q <= EXPO_OFF;
    end else begin
      expoMode_q <= regQ[IX_EMODE][1:0];
    end
  end

  // A programmed frame time is offered only while long integration is on;
  // zero tells the pipeline to use its own free-running frame time
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      frameTime_q <= '0;
    end else if (regQ[IX_LONGEN][0]) begin
      frameTime_q <= regQ[IX_FTIME][23:0];
    end else begin
      frameTime_q <= '0;
    end
  end

  assign hrdata              = hrdata_q;
  assign hreadyout           = hreadyout_q;
  assign hresp               = hresp_q;
  assign loadBusy            = loadBusy_q;
  assign bootSet             = bootSet_q;
  assign converterResolution = convRes_q;
  assign masterRegionMode    = regionMode_q;
  assign exposureMode        = expoMode_q;
  assign frameTimeUs         = frameTime_q;
  assign longIntegrationEn   = regQ[IX_LONGEN][0];
  assign analogGain          = regQ[IX_AGAIN][8:0];
  assign pixelGain           = regQ[IX_PGAIN][11:0];
  assign pixelOffset         = regQ[IX_POFS][10:0];
  assign masterRegionHOffset = regQ[IX_RHOFS][12:0];
  assign masterRegionHWidth  = regQ[IX_RHWID][12:0];
  assign masterRegionVOffset = regQ[IX_RVOFS][12:0];
  assign masterRegionVHeight = regQ[IX_RVHGT][12:0];
  assign hSubsampleEn        = regQ[IX_HSUB][0];
  assign vSubsampleEn        = regQ[IX_VSUB][0];
  assign vBinningEn          = regQ[IX_VBIN][0];
  assign mirrorEn            = regQ[IX_MIRROR][0];
  assign upsideDownEn        = regQ[IX_UPSD][0];
  assign blackLevelAuto      = regQ[IX_BLKMOD][0];
  assign blackLevelValue     = regQ[IX_BLKVAL][7:0];
  assign exposureTimeUs      = regQ[IX_ETIME][23:0];
  assign autoExposureLowerUs = regQ[IX_AELO][23:0];
  assign autoExposureUpperUs = regQ[IX_AEHI][23:0];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence restartWrite;
    busWr && wrRestart && hwdata == RESTART_KEY;
  endsequence
  sequence reloadRuns;
    !hreadyout ##1 loadBusy && !hreadyout ##1 cfgRdReq;
  endsequence

  restart_reload_a: assert property (restartWrite |=> reloadRuns)
    else $error("restart did not start a reload");
  reload_stall_a: assert property (ldBusy |=> !hreadyout)
    else $error("bus not stalled during reload");
  boot_fallback_a: assert property (
    regQ[IX_BOOT][2:0] > BOOT_USER4 |=> bootSet == BOOT_FACTORY)
    else $error("reserved boot set not treated as factory");
  boot_pass_a: assert property (
    regQ[IX_BOOT][2:0] <= BOOT_USER4 |=> bootSet == $past(regQ[IX_BOOT][2:0]))
    else $error("boot set not passed through");
  region_mode_a: assert property (
    regQ[IX_RMODE][1:0] == 2'h3 |=> masterRegionMode == REGION_OFF)
    else $error("reserved region mode not disabled");
  expo_mode_a: assert property (
    $changed(regQ[IX_EMODE]) && regQ[IX_EMODE][1:0] != 2'h3
    |=> exposureMode == $past(regQ[IX_EMODE][1:0]))
    else $error("exposure mode not followed");
  adc_res_a: assert property (
    regQ[IX_ADCRES][1:0] == 2'h3 |=> converterResolution == ADC_8)
    else $error("reserved resolution not defaulted");
  gain_store_a: assert property (
    busWr && wrHit && wrIdx == IX_AGAIN |=> analogGain == $past(hwdata[8:0])
    && regQ[IX_AGAIN][31:9] == '0)
    else $error("analog gain write lost");
  frame_gate_a: assert property (
    !regQ[IX_LONGEN][0] ##1 !regQ[IX_LONGEN][0] |-> frameTimeUs == '0)
    else $error("frame time offered without long integration");
  read_back_a: assert property (
    rdTake && rdHit && rdIdx == IX_ETIME && !busWr
    |=> hrdata == {8'h00, exposureTimeUs})
    else $error("exposure time read back wrong");
  unmapped_read_a: assert property (rdTake && !rdHit |=> hrdata == '0)
    else $error("unmapped read not zero");

  // The stall must keep bus writes and reload writes apart
  bus_load_apart_a: assert property (!(busWr && ldWr))
    else $error("bus write and reload write collide");
  wrong_key_a: assert property (
    busWr && wrRestart && hwdata != RESTART_KEY && !ldBusy && !restart_q
    |=> hreadyout)
    else $error("wrong restart key stalled the bus");
  load_lands_a: assert property (
    ldWr && ldIdx == IX_ETIME |=> exposureTimeUs == $past(ldData[23:0]))
    else $error("loaded exposure time lost");
  pgain_store_a: assert property (
    busWr && wrHit && wrIdx == IX_PGAIN
    |=> pixelGain == $past(hwdata[11:0]))
    else $error("digital gain write lost");
  pofs_store_a: assert property (
    busWr && wrHit && wrIdx == IX_POFS
    |=> pixelOffset == $past(hwdata[10:0]))
    else $error("digital offset write lost");
  region_hofs_a: assert property (
    busWr && wrHit && wrIdx == IX_RHOFS
    |=> masterRegionHOffset == $past(hwdata[12:0]))
    else $error("region offset write lost");
  black_value_a: assert property (
    busWr && wrHit && wrIdx == IX_BLKVAL
    |=> blackLevelValue == $past(hwdata[7:0]))
    else $error("black level value write lost");
  ae_upper_a: assert property (
    busWr && wrHit && wrIdx == IX_AEHI
    |=> autoExposureUpperUs == $past(hwdata[23:0]))
    else $error("upper exposure limit write lost");
  frame_pass_a: assert property (
    longIntegrationEn
    |=> frameTimeUs == $past(regQ[IX_FTIME][23:0]))
    else $error("frame time not offered with long integration");
endmodule : cic_camera_imaging_control_regs
`default_nettype wire

// ===== src/cic_pkg.sv
// Shared constants, types and decode helpers of the imaging control bank
package cic_pkg;
  localparam int NUM_REG = 23;
  localparam int NUM_CFG = 22;
  localparam int IW      = 5;
  localparam int AW      = 16;
  typedef logic [IW-1:0] cic_idx_t;

  localparam cic_idx_t IX_AGAIN  = 5'h00, IX_ADCRES = 5'h01, IX_RMODE = 5'h02;
  localparam cic_idx_t IX_RHOFS  = 5'h03, IX_RHWID  = 5'h04, IX_RVOFS = 5'h05;
  localparam cic_idx_t IX_RVHGT  = 5'h06, IX_HSUB   = 5'h07, IX_VSUB  = 5'h08;
  localparam cic_idx_t IX_VBIN   = 5'h09, IX_MIRROR = 5'h0A, IX_UPSD  = 5'h0B;
  localparam cic_idx_t IX_BLKMOD = 5'h0C, IX_BLKVAL = 5'h0D, IX_EMODE = 5'h0E;
  localparam cic_idx_t IX_ETIME  = 5'h0F, IX_LONGEN = 5'h10, IX_FTIME = 5'h11;
  localparam cic_idx_t IX_AELO   = 5'h12, IX_AEHI   = 5'h13, IX_POFS  = 5'h14;
  localparam cic_idx_t IX_PGAIN  = 5'h15, IX_BOOT   = 5'h16;
  localparam cic_idx_t IX_LASTCFG = 5'h15;

  localparam logic [AW-1:0] REG_OFS [NUM_REG] = '{
    16'h0000, 16'h0008, 16'h0010, 16'h0014, 16'h0018, 16'h001C, 16'h0020,
    16'h0024, 16'h0028, 16'h002C, 16'h0030, 16'h0034, 16'h0038, 16'h003C,
    16'h0040, 16'h0044, 16'h0048, 16'h004C, 16'h0058, 16'h005C, 16'h015C,
    16'h0160, 16'h5000};
  localparam logic [5:0] REG_BITS [NUM_REG] = '{
    6'h09, 6'h02, 6'h02, 6'h0D, 6'h0D, 6'h0D, 6'h0D, 6'h01, 6'h01, 6'h01,
    6'h01, 6'h01, 6'h01, 6'h08, 6'h02, 6'h18, 6'h01, 6'h18, 6'h18, 6'h18,
    6'h0B, 6'h0C, 6'h03};
  localparam logic [AW-1:0] OFS_RESTART = 16'h5004;
  localparam logic [31:0]   RESTART_KEY = 32'hDEADBEEF;

  typedef enum logic [2:0] {BOOT_FACTORY = 3'h0, BOOT_USER1 = 3'h1,
    BOOT_USER2 = 3'h2, BOOT_USER3 = 3'h3, BOOT_USER4 = 3'h4} cic_boot_t;
  typedef enum logic [1:0] {REGION_OFF = 2'h0, REGION_FAST = 2'h1,
    REGION_CONST = 2'h2} cic_region_t;
  typedef enum logic [1:0] {EXPO_OFF = 2'h0, EXPO_PULSE = 2'h1,
    EXPO_TIMED = 2'h2} cic_expo_t;
  typedef enum logic [1:0] {ADC_8 = 2'h0, ADC_10 = 2'h1,
    ADC_12 = 2'h2} cic_adc_t;
  typedef enum logic [1:0] {LD_IDLE = 2'b00, LD_REQ = 2'b01,
    LD_WAIT = 2'b10} cic_ld_state_t;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;
  localparam logic       HRESP_OKAY    = 1'b0;

  function automatic logic [31:0] cic_mask(input logic [5:0] bits);
    logic [63:0] m;
    m = (64'h1 << bits) - 64'h1;
    return m[31:0];
  endfunction : cic_mask

  // Returns {hit, index}; the upper address bits must be zero for a hit
  function automatic logic [IW:0] cic_decode(input logic [31:0] a);
    logic [IW:0] r;
    r = '0;
    for (int i = 0; i < NUM_REG; i++) begin
      if (a[31:AW] == '0 && a[AW-1:0] == REG_OFS[i]) begin
        r = {1'b1, IW'(i)};
      end
    end
    return r;
  endfunction : cic_decode
endpackage : cic_pkg

// ===== verif/tb_cic_camera_imaging_control_regs.sv
// Self-checking bench for the imaging control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_cic_camera_imaging_control_regs
  import cic_pkg::*;
;
  // Field widths in register order, kept apart from the design's own table
  localparam int FW [NUM_REG] = '{9, 2, 2, 13, 13, 13, 13, 1, 1, 1, 1, 1, 1,
                                  8, 2, 24, 1, 24, 24, 24, 11, 12, 3};
  localparam int LIMIT = 20000;

  logic        clk_sys, nrst, hsel, hwrite, cfgRdValid;
  logic [31:0] haddr, hwdata, cfgRdData, hrdata;
  logic [1:0]  htrans, rCnt;
  logic [2:0]  hsize, cfgRdSet, bootSet, rSet;
  logic [4:0]  cfgRdIndex, rIdx;
  logic        hready, hreadyout, hresp, cfgRdReq, loadBusy;
  logic [8:0]  analogGain;
  logic [11:0] pixelGain;
  logic [10:0] pixelOffset;
  logic [1:0]  converterResolution, masterRegionMode, exposureMode;
  logic [12:0] masterRegionHOffset, masterRegionHWidth;
  logic [12:0] masterRegionVOffset, masterRegionVHeight;
  logic        hSubsampleEn, vSubsampleEn, vBinningEn, mirrorEn;
  logic        upsideDownEn, blackLevelAuto, longIntegrationEn;
  logic [7:0]  blackLevelValue;
  logic [23:0] exposureTimeUs, frameTimeUs;
  logic [23:0] autoExposureLowerUs, autoExposureUpperUs;
  int          err_count, check_count, cycles, reqCnt, n;

  assign hready = hreadyout;

  cic_camera_imaging_control_regs i_cic_camera_imaging_control_regs (
    .clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .cfgRdValid, .cfgRdData,
    .cfgRdReq, .cfgRdSet, .cfgRdIndex, .loadBusy, .bootSet, .analogGain,
    .pixelGain, .pixelOffset, .converterResolution, .masterRegionMode,
    .masterRegionHOffset, .masterRegionHWidth, .masterRegionVOffset,
    .masterRegionVHeight, .hSubsampleEn, .vSubsampleEn, .vBinningEn,
    .mirrorEn, .upsideDownEn, .blackLevelAuto, .blackLevelValue,
    .exposureMode, .exposureTimeUs, .longIntegrationEn, .frameTimeUs,
    .autoExposureLowerUs, .autoExposureUpperUs);

  always #20 clk_sys = ~clk_sys;

  function automatic logic [31:0] pat(input logic [2:0] s,
                                      input logic [4:0] i);
    return {s, i, ~s, ~i, s, i, 8'h96};
  endfunction : pat

  function automatic logic [31:0] msk(input int w);
    logic [63:0] m;
    m = (64'h1 << w) - 64'h1;
    return m[31:0];
  endfunction : msk

  // Configuration space: answers quickly for even words, slowly for odd
  always @(posedge clk_sys) begin
    cfgRdValid <= (cfgRdReq !== 1'b1) && (rCnt == 2'h1);
    // Data lines churn outside the answer cycle so stale data cannot pass
    cfgRdData <= (cfgRdReq !== 1'b1 && rCnt == 2'h1) ? pat(rSet, rIdx)
                                                       : ~cfgRdData;
    if (cfgRdReq === 1'b1) begin
      rSet <= cfgRdSet;
      rIdx <= cfgRdIndex;
      rCnt <= cfgRdIndex[0] ? 2'h3 : 2'h1;
      reqCnt <= reqCnt + 1;
    end else if (rCnt != 2'h0) begin
      rCnt <= rCnt - 2'h1;
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Address phase held until hready, then data phase until hready again
  task automatic ahb(input logic w, input logic [2:0] sz,
                     input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= sz;
    haddr <= a;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    if (w) hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY}, "response");
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, HSIZE_WORD, a, d, r);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e,
                    input string m);
    logic [31:0] r;
    ahb(1'b0, HSIZE_WORD, a, 32'h0, r);
    chk(r, e, m);
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge clk_sys);
  endtask : settle

  task automatic scan(input logic [2:0] s);
    for (int i = 0; i < NUM_CFG; i++) begin
      rd(32'(REG_OFS[i]), pat(s, 5'(i)) & msk(FW[i]), "reload");
    end
    chk(32'(rSet), 32'(s), "loaded set");
  endtask : scan

  initial begin
    logic [31:0] r;
    logic [1:0]  e;
    clk_sys = 1'b0;
    nrst = 1'b0;
    {hsel, hwrite, cfgRdValid, rCnt, rSet, rIdx} = '0;
    {haddr, hwdata, cfgRdData, htrans, hsize} = '0;
    {err_count, check_count, cycles, reqCnt} = '0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    scan(3'h0);
    chk(32'(reqCnt), 32'd22, "request count");
    for (int i = 0; i < NUM_REG; i++) begin
      wr(32'(REG_OFS[i]), 32'hFFFFFFFF);
      rd(32'(REG_OFS[i]), msk(FW[i]), "ones");
    end
    settle();
    chk(32'(analogGain), 32'h1FF, "analog gain");
    chk(32'(pixelGain), 32'hFFF, "pixel gain");
    chk(32'(pixelOffset), 32'h7FF, "pixel offset");
    chk({masterRegionHOffset, masterRegionHWidth, 6'h0}, 32'hFFFFFFC0,
        "region h");
    chk({masterRegionVOffset, masterRegionVHeight, 6'h0}, 32'hFFFFFFC0,
        "region v");
    chk(32'({hSubsampleEn, vSubsampleEn}), 32'h3, "subsample");
    chk(32'(vBinningEn), 32'h1, "binning");
    chk(32'({mirrorEn, upsideDownEn}), 32'h3, "flips");
    chk(32'(blackLevelAuto), 32'h1, "black mode");
    chk(32'(blackLevelValue), 32'hFF, "black value");
    chk(32'(exposureTimeUs), 32'hFFFFFF, "exposure time");
    chk(32'(frameTimeUs), 32'hFFFFFF, "frame time on");
    chk(32'(longIntegrationEn), 32'h1, "long on");
    chk({autoExposureLowerUs, 8'h0}, 32'hFFFFFF00, "ae low");
    chk({autoExposureUpperUs, 8'h0}, 32'hFFFFFF00, "ae high");
    chk(32'(bootSet), 32'h0, "boot reserved");
    for (int i = 0; i < NUM_REG; i++) begin
      wr(32'(REG_OFS[i]), 32'h0);
      rd(32'(REG_OFS[i]), 32'h0, "zeros");
    end
    wr(32'(REG_OFS[IX_FTIME]), 32'h00FFFFFF);
    settle();
    chk(32'(frameTimeUs), 32'h0, "frame time off");
    chk(32'(longIntegrationEn), 32'h0, "long off");
    chk(32'(blackLevelAuto), 32'h0, "black user");
    for (int v = 0; v < 4; v++) begin
      e = (v == 3) ? 2'h0 : 2'(v);
      wr(32'(REG_OFS[IX_ADCRES]), 32'(v));
      wr(32'(REG_OFS[IX_RMODE]), 32'(v));
      wr(32'(REG_OFS[IX_EMODE]), 32'(v));
      settle();
      chk(32'(converterResolution), 32'(e), "resolution");
      chk(32'(masterRegionMode), 32'(e), "region mode");
      chk(32'(exposureMode), 32'(e), "exposure mode");
      rd(32'(REG_OFS[IX_EMODE]), 32'(v), "raw mode");
    end
    // Unmapped places and sub-word writes leave the bank untouched
    wr(32'h00000004, 32'hFFFFFFFF);
    wr(32'h00015000, 32'h7);
    rd(32'h00000004, 32'h0, "unmapped");
    rd(32'(OFS_RESTART), 32'h0, "restart read");
    rd(32'(REG_OFS[IX_BOOT]), 32'h0, "alias");
    ahb(1'b1, 3'h0, 32'(REG_OFS[IX_AGAIN]), 32'h55, r);
    rd(32'(REG_OFS[IX_AGAIN]), 32'h0, "byte write");
    for (int s = 1; s < 5; s++) begin
      wr(32'(REG_OFS[IX_BOOT]), 32'(s));
      settle();
      chk(32'(bootSet), 32'(s), "boot user");
    end
    wr(32'(REG_OFS[IX_BOOT]), 32'h5);
    rd(32'(REG_OFS[IX_BOOT]), 32'h5, "boot raw");
    settle();
    chk(32'(bootSet), 32'h0, "boot reserved");
    wr(32'(REG_OFS[IX_BOOT]), 32'h3);
    wr(32'(OFS_RESTART), 32'h12345678);
    settle();
    chk(32'(loadBusy), 32'h0, "wrong key");
    n = reqCnt;
    wr(32'(OFS_RESTART), RESTART_KEY);
    @(posedge clk_sys);
    chk(32'(loadBusy), 32'h1, "reload busy");
    scan(3'h3);
    chk(32'(reqCnt - n), 32'd22, "restart count");
    rd(32'(REG_OFS[IX_BOOT]), 32'h3, "boot kept");
    wr(32'(REG_OFS[IX_BOOT]), 32'h6);
    wr(32'(OFS_RESTART), RESTART_KEY);
    scan(3'h0);
    // Mid-run power-style reset clears the selector and reloads factory
    nrst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(32'(hreadyout), 32'h0, "reset stall");
    nrst <= 1'b1;
    scan(3'h0);
    rd(32'(REG_OFS[IX_BOOT]), 32'h0, "boot cleared");
    print_verdict();
  end
endmodule : tb_cic_camera_imaging_control_regs
`default_nettype wire
